// ---- verilog/aux_ctrl_pkg.sv ----
/*
  Shared constants and types of the auxiliary core control registers:
  coprocessor transfer codes, field positions, reset values, write masks,
  and the packed layouts of both registers.
  Assumes nothing of its surroundings.
*/
package aux_ctrl_pkg;

  // ==========================================================
  // Coprocessor transfer codes of the two registers
  // ==========================================================
  localparam logic [3:0] AUX_CRN = 4'h1;
  localparam logic [2:0] AUX_OPC1 = 3'h0;
  localparam logic [3:0] AUX_CRM = 4'h0;
  localparam logic [2:0] AUX_OPC2 = 3'h1;
  localparam logic [3:0] SEC_CRN = 4'hf;
  localparam logic [2:0] SEC_OPC1 = 3'h0;
  localparam logic [3:0] SEC_CRM = 4'h0;
  localparam logic [2:0] SEC_OPC2 = 3'h0;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int AUX_CASE_C_POS = 31;
  localparam int AUX_CASE_A_POS = 28;
  localparam int AUX_CHECK_B1_POS = 27;
  localparam int AUX_CHECK_A_POS = 25;
  localparam int AUX_SLAVE_EN_POS = 24;
  localparam int AUX_SLAVE_USER_POS = 23;
  localparam int AUX_PARITY_INJ_POS = 12;
  localparam int AUX_CEC_LSB = 3;
  localparam int AUX_EXT_B1_POS = 2;
  localparam int AUX_EXT_A_POS = 0;
  localparam int SEC_HARD_ERR_POS = 22;
  localparam int SEC_TWO_BIT_POS = 21;
  localparam int SEC_FP6_POS = 20;
  localparam int SEC_FP2_POS = 19;

  // ==========================================================
  // Reset values and write masks
  // ==========================================================
  localparam logic [2:0] CEC_RESET = 3'h4;
  localparam logic [1:0] POLICY_RESET = 2'h0;
  // Fixed reset part; configuration-driven bits are loaded after release
  localparam logic [31:0] AUX_RESET = 32'h0000_0020;
  localparam logic [31:0] SEC_RESET = 32'h0040_0000;
  // Bit 18 of the first register and bits 31:23 and 18:0 of the second are SBZ
  localparam logic [31:0] AUX_WMASK = 32'hfffb_ffff;
  localparam logic [31:0] SEC_WMASK = 32'h0078_0000;

  // ==========================================================
  // Prediction policy encodings
  // ==========================================================
  localparam logic [1:0] POLICY_NORMAL = 2'h0;
  localparam logic [1:0] POLICY_TAKEN = 2'h1;
  localparam logic [1:0] POLICY_NOT_TAKEN = 2'h2;

  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_AUX,
    SEL_SEC
  } reg_sel_t;

  typedef struct packed {
    logic dual_issue_case_c_off;
    logic dual_issue_case_b2_off;
    logic dual_issue_case_b1_off;
    logic dual_issue_case_a_off;
    logic port_b1_check_en;
    logic port_b0_check_en;
    logic port_a_check_en;
    logic slave_cache_ram_en;
    logic slave_cache_ram_user_en;
    logic lil_multiple_off;
    logic loop_predict_off;
    logic branch_history_ext_off;
    logic fetch_rate_ctrl_off;
    logic rsvd18;
    logic return_stack_off;
    logic [1:0] predict_policy;
    logic write_burst_off;
    logic linefill_opt_off;
    logic parity_inject_en;
    logic noncache_forward_off;
    logic force_read_alloc;
    logic force_write_through;
    logic force_data_nonshared;
    logic divide_result_inorder;
    logic lil_all_loadstore_off;
    logic [2:0] cache_error_ctrl;
    logic port_b1_ext_err_en;
    logic port_b0_ext_err_en;
    logic port_a_ext_err_en;
  } aux_reg_t;

  typedef struct packed {
    logic [8:0] rsvd_hi;
    logic hard_error_recovery_off;
    logic two_bit_inject_en;
    logic fp_case6_dual_off;
    logic fp_case2_dual_off;
    logic [18:0] rsvd_lo;
  } sec_reg_t;

  // Coprocessor register transfer request
  typedef struct packed {
    logic valid;
    logic write;
    logic priv;
    logic [3:0] crn;
    logic [2:0] opc1;
    logic [3:0] crm;
    logic [2:0] opc2;
    logic [31:0] wdata;
  } cp_req_t;

  // Answer to a transfer, one cycle after it is taken
  typedef struct packed {
    logic ack;
    logic undef;
    logic [31:0] rdata;
  } cp_rsp_t;

  typedef struct packed {
    aux_reg_t aux;
    sec_reg_t sec;
    logic cfg_loaded;
    cp_rsp_t rsp;
    logic maint_undef;
  } ctrl_state_t;

endpackage

// ---- verilog/cp_access_decode.sv ----
/*
  Decodes a coprocessor transfer into the register it selects and whether
  it must be refused as undefined.
  Assumes the request fields are stable while valid is high.
*/
`timescale 1ns/10ps
module cp_access_decode (
  input wire aux_ctrl_pkg::cp_req_t req_in,
  output aux_ctrl_pkg::reg_sel_t sel_out,
  output logic undef_out
);
  import aux_ctrl_pkg::*;

  always_comb begin
    sel_out = SEL_NONE;
    if (req_in.valid && req_in.crn == AUX_CRN && req_in.opc1 == AUX_OPC1 &&
        req_in.crm == AUX_CRM && req_in.opc2 == AUX_OPC2) begin
      sel_out = SEL_AUX;
    end else if (req_in.valid && req_in.crn == SEC_CRN && req_in.opc1 == SEC_OPC1 &&
                 req_in.crm == SEC_CRM && req_in.opc2 == SEC_OPC2) begin
      sel_out = SEL_SEC;
    end
    // User-mode access to either register is undefined
    undef_out = (sel_out != SEL_NONE) && !req_in.priv;
  end

endmodule

// ---- verilog/aux_core_control_registers.sv ----
/*
  Auxiliary and secondary auxiliary control registers of the core, reached
  by coprocessor register transfers, with their control fields driven out
  to the pipeline, prefetch, bus master and memory error logic.
  Assumes requests and configuration inputs are synchronous to clk_in and
  that the configuration inputs are stable around reset release.
*/
// What this block does
// - Dual-issue case bits reset 0, 1 disables
// - Port check enables reset from check config
// - Slave cache access turns caching, maintenance off
// - Bit 23 permits non-privileged slave accesses
// - Bits 22, 6 turn off low latency
// - Bits 21, 20 disable loop, history extension
// - Bits 19, 17 disable fetch rate, return stack
// - Bits 16:15 select branch prediction policy
// - Bit 14 disables master write bursts
// - Bit 13 limits linefills to two
// - Bit 12 enables parity injection if built
// - Bit 11 stops non-cacheable data forwarding
// - Bits 10, 9 force read-allocate, write-through
// - Bit 8 forces data non-shared, protection off
// - Bit 7 keeps divide result move in order
// - Cache error control field resets to 100
// - External error enables reset from config
// - Secondary bit 22 resets 1, hard errors fatal
// - Secondary bit 21 two-bit injection, needs ECC
// - Secondary bits 20, 19 disable FP dual issue
`timescale 1ns/10ps
module aux_core_control_registers #(
  parameter bit PARITY_GEN_BUILT = 1'b1,
  parameter bit ECC_BUILT = 1'b1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire aux_ctrl_pkg::cp_req_t cp_req_in,
  output aux_ctrl_pkg::cp_rsp_t cp_rsp_out,
  input wire logic [2:0] check_enable_cfg_in,
  input wire logic [2:0] ext_err_enable_cfg_in,
  input wire logic cache_maint_req_in,
  output logic cache_maint_undef_out,
  input wire logic cache_enable_req_in,
  output logic cache_enable_out,
  input wire logic slave_ram_req_in,
  input wire logic slave_ram_priv_in,
  output logic slave_ram_grant_out,
  output logic slave_ram_refuse_out,
  input wire logic mpu_enabled_in,
  output logic force_data_nonshared_out,
  output logic predict_always_taken_out,
  output logic predict_always_not_taken_out,
  output logic predict_history_frozen_out,
  output logic max_two_linefills_out,
  output aux_ctrl_pkg::aux_reg_t aux_ctrl_reg_out,
  output aux_ctrl_pkg::sec_reg_t sec_ctrl_reg_out
);
  import aux_ctrl_pkg::*;

  // ==========================================================
  // State
  // ==========================================================
  ctrl_state_t state_ff;
  ctrl_state_t nxt_state;
  reg_sel_t sel;
  logic req_undef;
  logic [31:0] aux_wmask_eff;
  logic [31:0] sec_wmask_eff;

  cp_access_decode u_decode (
    .req_in(cp_req_in),
    .sel_out(sel),
    .undef_out(req_undef)
  );

  // Injection bits are read-as-zero where the generator was not built
  always_comb begin
    aux_wmask_eff = AUX_WMASK;
    aux_wmask_eff[AUX_PARITY_INJ_POS] = PARITY_GEN_BUILT;
    sec_wmask_eff = SEC_WMASK;
    sec_wmask_eff[SEC_TWO_BIT_POS] = ECC_BUILT;
  end

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    nxt_state = state_ff;
    nxt_state.rsp.ack = 1'b0;
    nxt_state.rsp.undef = 1'b0;
    nxt_state.maint_undef = 1'b0;

    // Configuration-driven reset values are caught on the first edge after
    // release, because an async reset may only load constants.
    if (!state_ff.cfg_loaded) begin
      nxt_state.cfg_loaded = 1'b1;
      nxt_state.aux.port_b1_check_en = check_enable_cfg_in[2];
      nxt_state.aux.port_b0_check_en = check_enable_cfg_in[1];
      nxt_state.aux.port_a_check_en = check_enable_cfg_in[0];
      nxt_state.aux.port_b1_ext_err_en = ext_err_enable_cfg_in[2];
      nxt_state.aux.port_b0_ext_err_en = ext_err_enable_cfg_in[1];
      nxt_state.aux.port_a_ext_err_en = ext_err_enable_cfg_in[0];
    end else if (sel != SEL_NONE) begin
      nxt_state.rsp.ack = 1'b1;
      nxt_state.rsp.rdata = '0;
      if (req_undef) begin
        // Refused access changes nothing and returns zero
        nxt_state.rsp.undef = 1'b1;
      end else if (cp_req_in.write) begin
        // Masked write keeps SBZ bits at zero
        if (sel == SEL_AUX) begin
          nxt_state.aux = aux_reg_t'(cp_req_in.wdata & aux_wmask_eff);
        end else begin
          nxt_state.sec = sec_reg_t'(cp_req_in.wdata & sec_wmask_eff);
        end
      end else if (sel == SEL_AUX) begin
        nxt_state.rsp.rdata = 32'(state_ff.aux);
      end else begin
        nxt_state.rsp.rdata = 32'(state_ff.sec);
      end
    end

    // Maintenance is impossible while the slave owns the cache RAMs
    nxt_state.maint_undef = cache_maint_req_in && state_ff.aux.slave_cache_ram_en;
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      // Pipeline bits reset to features-on
      state_ff.aux <= aux_reg_t'(AUX_RESET);
      state_ff.sec <= sec_reg_t'(SEC_RESET);
      state_ff.cfg_loaded <= 1'b0;
      state_ff.rsp <= '0;
      state_ff.maint_undef <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign cp_rsp_out = state_ff.rsp;
  assign cache_maint_undef_out = state_ff.maint_undef;
  assign aux_ctrl_reg_out = state_ff.aux;
  assign sec_ctrl_reg_out = state_ff.sec;

  // Caching is held off while the slave may touch the cache RAMs
  assign cache_enable_out = cache_enable_req_in && !state_ff.aux.slave_cache_ram_en;

  // Non-privileged slave access also needs its own permission bit
  assign slave_ram_grant_out = slave_ram_req_in && state_ff.aux.slave_cache_ram_en &&
                               (slave_ram_priv_in || state_ff.aux.slave_cache_ram_user_en);
  assign slave_ram_refuse_out = slave_ram_req_in && !slave_ram_grant_out;

  assign force_data_nonshared_out = state_ff.aux.force_data_nonshared && !mpu_enabled_in;

  // Policy 11 behaves as normal here; software must not select it
  assign predict_always_taken_out = state_ff.aux.predict_policy == POLICY_TAKEN;
  assign predict_always_not_taken_out = state_ff.aux.predict_policy == POLICY_NOT_TAKEN;
  assign predict_history_frozen_out = predict_always_taken_out || predict_always_not_taken_out;

  assign max_two_linefills_out = state_ff.aux.linefill_opt_off;

endmodule

// ---- bench/aux_ctrl_asserts.sv ----
/*
  Port checker of the auxiliary control registers, bound to the top module.
  Assumes default build parameters.
*/
`timescale 1ns/10ps
module aux_ctrl_asserts
  import aux_ctrl_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire cp_req_t cp_req_in,
  input wire cp_rsp_t cp_rsp_out,
  input wire logic cache_maint_req_in,
  input wire logic cache_maint_undef_out,
  input wire logic cache_enable_req_in,
  input wire logic cache_enable_out,
  input wire logic slave_ram_req_in,
  input wire logic slave_ram_priv_in,
  input wire logic slave_ram_grant_out,
  input wire logic slave_ram_refuse_out,
  input wire logic predict_always_taken_out,
  input wire logic predict_always_not_taken_out,
  input wire aux_reg_t aux_ctrl_reg_out,
  input wire sec_reg_t sec_ctrl_reg_out
);
  logic aux_hit;
  logic sec_hit;
  logic en;
  assign en = aux_ctrl_reg_out.slave_cache_ram_en;
  assign aux_hit = cp_req_in.valid && {cp_req_in.crn, cp_req_in.opc1, cp_req_in.crm, cp_req_in.opc2}
    == {AUX_CRN, AUX_OPC1, AUX_CRM, AUX_OPC2};
  assign sec_hit = cp_req_in.valid && {cp_req_in.crn, cp_req_in.opc1, cp_req_in.crm, cp_req_in.opc2}
    == {SEC_CRN, SEC_OPC1, SEC_CRM, SEC_OPC2};
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ==========================================================
  // Transfers and side outputs
  a_ack_answer: assert property (
    (aux_hit || sec_hit) |=> cp_rsp_out.ack && cp_rsp_out.undef == !$past(cp_req_in.priv))
    else $error("answer missing or wrong");
  a_no_answer: assert property (
    !(aux_hit || sec_hit) |=> !cp_rsp_out.ack) else $error("answer to no request");
  a_user_refuse: assert property (
    (aux_hit || sec_hit) && !cp_req_in.priv |=> cp_rsp_out.rdata == 32'h0
    && $stable(aux_ctrl_reg_out) && $stable(sec_ctrl_reg_out)) else $error("user access changed state");
  a_aux_write: assert property (
    aux_hit && cp_req_in.write && cp_req_in.priv |=> aux_ctrl_reg_out == ($past(cp_req_in.wdata) & AUX_WMASK))
    else $error("aux write wrong");
  a_sec_write: assert property (
    sec_hit && cp_req_in.write && cp_req_in.priv |=> sec_ctrl_reg_out == ($past(cp_req_in.wdata) & SEC_WMASK))
    else $error("sec write wrong");
  a_maint_undef: assert property (
    1'b1 |=> cache_maint_undef_out == $past(cache_maint_req_in && en)) else $error("maint undef wrong");
  a_slave_grant: assert property (
    slave_ram_grant_out == (slave_ram_req_in && en && (slave_ram_priv_in || aux_ctrl_reg_out.slave_cache_ram_user_en))
    && slave_ram_refuse_out == (slave_ram_req_in && !slave_ram_grant_out)
    && cache_enable_out == (cache_enable_req_in && !en)) else $error("slave or cache gate wrong");
  a_policy_out: assert property (
    predict_always_taken_out == (aux_ctrl_reg_out.predict_policy == POLICY_TAKEN)
    && predict_always_not_taken_out == (aux_ctrl_reg_out.predict_policy == POLICY_NOT_TAKEN))
    else $error("policy outputs wrong");
  c_user_refuse: cover property ((aux_hit || sec_hit) && !cp_req_in.priv);
  c_maint_undef: cover property (cache_maint_undef_out);
  c_grant: cover property (slave_ram_grant_out);
endmodule
bind aux_core_control_registers aux_ctrl_asserts chk_u (.clk_in(clk_in), .rst_in(rst_in),
  .cp_req_in(cp_req_in), .cp_rsp_out(cp_rsp_out), .cache_maint_req_in(cache_maint_req_in),
  .cache_maint_undef_out(cache_maint_undef_out), .cache_enable_req_in(cache_enable_req_in),
  .cache_enable_out(cache_enable_out), .slave_ram_req_in(slave_ram_req_in),
  .slave_ram_priv_in(slave_ram_priv_in), .slave_ram_grant_out(slave_ram_grant_out),
  .slave_ram_refuse_out(slave_ram_refuse_out), .predict_always_taken_out(predict_always_taken_out),
  .predict_always_not_taken_out(predict_always_not_taken_out), .aux_ctrl_reg_out(aux_ctrl_reg_out),
  .sec_ctrl_reg_out(sec_ctrl_reg_out));

// ---- bench/aux_core_control_registers_tb_top.sv ----
/*
  Self-checking bench of the auxiliary control registers against a model.
  Assumes default build parameters and the checker bound beside it.
*/
`timescale 1ns/10ps
module aux_core_control_registers_tb_top;
  import aux_ctrl_pkg::*;
  logic clk_in, rst_in, maint_req, maint_undef, cen_req, cen, sreq, spriv, grant, refuse, mpu;
  logic fdn, pt, pn, pf, m2;
  logic [2:0] check_cfg, ext_cfg;
  cp_req_t req;
  cp_rsp_t rsp;
  aux_reg_t aux_o;
  sec_reg_t sec_o;
  logic [31:0] aux_m, sec_m, rs;
  int n_mismatch, checks;
  aux_core_control_registers dut_u (.clk_in(clk_in), .rst_in(rst_in), .cp_req_in(req), .cp_rsp_out(rsp),
    .check_enable_cfg_in(check_cfg), .ext_err_enable_cfg_in(ext_cfg), .cache_maint_req_in(maint_req),
    .cache_maint_undef_out(maint_undef), .cache_enable_req_in(cen_req), .cache_enable_out(cen),
    .slave_ram_req_in(sreq), .slave_ram_priv_in(spriv), .slave_ram_grant_out(grant),
    .slave_ram_refuse_out(refuse), .mpu_enabled_in(mpu), .force_data_nonshared_out(fdn),
    .predict_always_taken_out(pt), .predict_always_not_taken_out(pn), .predict_history_frozen_out(pf),
    .max_two_linefills_out(m2), .aux_ctrl_reg_out(aux_o), .sec_ctrl_reg_out(sec_o));
  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // One transfer; sel 0 aux, 1 secondary, 2 an unmapped code
  task automatic cp(input logic wr, input logic pv, input int sel, input logic [31:0] d);
    logic [31:0] e;
    @(posedge clk_in);
    #1;
    req = '0;
    req.valid = 1'b1;
    req.write = wr;
    req.priv = pv;
    req.crn = (sel == 0) ? AUX_CRN : (sel == 1) ? SEC_CRN : 4'h2;
    req.opc2 = (sel == 0) ? AUX_OPC2 : SEC_OPC2;
    req.wdata = d;
    @(posedge clk_in);
    #1;
    req.valid = 1'b0;
    e = (wr || !pv) ? 32'h0 : (sel == 0) ? aux_m : sec_m;
    chk("ack", {31'h0, sel != 2}, {31'h0, rsp.ack});
    if (sel != 2) begin
      chk("undef", {31'h0, !pv}, {31'h0, rsp.undef});
      chk("rdata", e, rsp.rdata);
    end
    if (wr && pv && sel == 0) aux_m = d & AUX_WMASK;
    if (wr && pv && sel == 1) sec_m = d & SEC_WMASK;
    chk("aux", aux_m, aux_o);
    chk("sec", sec_m, sec_o);
  endtask
  // Side outputs with random inputs, plus one maintenance attempt
  task automatic side();
    logic [31:0] r;
    logic [31:0] e;
    logic g;
    r = rnd();
    {mpu, cen_req, spriv, sreq} = r[3:0];
    maint_req = 1'b1;
    @(posedge clk_in);
    #1;
    maint_req = 1'b0;
    g = sreq & aux_m[24] & (spriv | aux_m[23]);
    e = {23'h0, aux_m[24], g, sreq & ~g, cen_req & ~aux_m[24], aux_m[8] & ~mpu, aux_m[16:15] == 2'h1,
      aux_m[16:15] == 2'h2, aux_m[16:15] == 2'h1 || aux_m[16:15] == 2'h2, aux_m[13]};
    chk("side", e, {23'h0, maint_undef, grant, refuse, cen, fdn, pt, pn, pf, m2});
  endtask
  // ==========================================================
  // Sequence
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    #200000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    logic [31:0] w;
    rs = 32'h3a;
    n_mismatch = 0;
    checks = 0;
    req = '0;
    {maint_req, cen_req, sreq, spriv, mpu} = 5'h0;
    check_cfg = 3'h5;
    ext_cfg = 3'h3;
    rst_in = 1'b1;
    repeat (5) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    @(posedge clk_in);
    aux_m = AUX_RESET | {4'h0, check_cfg, 22'h0, ext_cfg};
    sec_m = SEC_RESET;
    cp(1'b0, 1'b1, 0, 32'h0);
    cp(1'b0, 1'b1, 1, 32'h0);
    for (int i = 0; i < 24; i++) begin
      w = (rnd() & 32'hfffe_7fff) | (32'((i / 2) % 4) << 15);
      // Both B-port check bits travel together, as software must keep them
      w[27] = w[26];
      cp(1'b1, 1'b1, i % 2, w);
      cp(1'b0, 1'b1, i % 2, 32'h0);
      side();
    end
    cp(1'b1, 1'b0, 0, 32'hffff_ffff);
    cp(1'b0, 1'b0, 1, 32'h0);
    cp(1'b1, 1'b1, 2, 32'hffff_ffff);
    cp(1'b1, 1'b1, 0, 32'h0100_0000);
    side();
    complete_run();
  end
endmodule
